// >>> pkg/e1tsm_pkg.sv
package e1tsm_pkg;
  // Register offsets (byte offsets on the 8-bit port, word index on APB).
  localparam logic [7:0] CTRL_FOUR_IDX    = 8'hA8;
  localparam logic [7:0] TX_CAPTURE_IDX   = 8'hA9;
  localparam logic [7:0] CTRL_FIVE_IDX    = 8'hAA;
  localparam logic [7:0] RX_CAPTURE_IDX   = 8'hAB;
  localparam logic [9:0] CTRL_FOUR_ADDR   = {CTRL_FOUR_IDX, 2'b00};
  localparam logic [9:0] TX_CAPTURE_ADDR  = {TX_CAPTURE_IDX, 2'b00};
  localparam logic [9:0] CTRL_FIVE_ADDR   = {CTRL_FIVE_IDX, 2'b00};
  localparam logic [9:0] RX_CAPTURE_ADDR  = {RX_CAPTURE_IDX, 2'b00};
  // Field layout.
  localparam int         SEL_LSB          = 0;
  localparam int         SEL_MSB          = 4;
  localparam int         LOOPBACK_BIT     = 7;
  localparam logic [7:0] CTRL_FOUR_MASK   = 8'h9F;
  localparam logic [7:0] CTRL_FIVE_MASK   = 8'h7F;
  // Reset values.
  localparam logic [7:0] CTRL_RESET       = 8'h00;
  localparam logic [7:0] CAPTURE_RESET    = 8'h00;
  // Frame timing: 32 slots of 8 bits.
  localparam int         SLOTS_PER_FRAME  = 32;
  localparam int         BITS_PER_SLOT    = 8;
endpackage

// >>> design/e1tsm_monitor.sv
// How it works
// - One transmit and one receive channel monitored at once, selected independently.
// - Transmit select is control-four bits 4..0, bit 0 least significant.
// - Receive select is a separate five-bit field in control-five.
// - Selected transmit octet lands at A9, receive octet in its own register.
// - Bit 7 holds the first bit on the line, bit 0 the last.
// - Receive select is control-five bits 4..0, bit 0 least significant.
`timescale 1ns/1ps
module e1tsm_monitor (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        tx_data,
  input  wire logic        tx_frame_sync,
  input  wire logic        tx_bit_valid,
  input  wire logic        rx_data,
  input  wire logic        rx_frame_sync,
  input  wire logic        rx_bit_valid,
  output logic             remote_loopback_enable
);

  logic [7:0] common_control_four_q;
  logic [7:0] common_control_five_q;
  logic [7:0] tx_slot_octet_capture_q;
  logic [7:0] rx_slot_octet_capture_q;
  logic       mapped;
  logic [7:0] rd_byte;
  logic       wr_en;

  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;

  always_comb begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    if (paddr[9:0] == e1tsm_pkg::CTRL_FOUR_ADDR && paddr[11:10] == 2'b00) begin
      rd_byte = common_control_four_q;
    end else if (paddr[9:0] == e1tsm_pkg::TX_CAPTURE_ADDR && paddr[11:10] == 2'b00) begin
      rd_byte = tx_slot_octet_capture_q;
    end else if (paddr[9:0] == e1tsm_pkg::CTRL_FIVE_ADDR && paddr[11:10] == 2'b00) begin
      rd_byte = common_control_five_q;
    end else if (paddr[9:0] == e1tsm_pkg::RX_CAPTURE_ADDR && paddr[11:10] == 2'b00) begin
      rd_byte = rx_slot_octet_capture_q;
    end else begin
      mapped = 1'b0;
    end
  end

  // Writes to the capture registers are refused, as are unmapped addresses.
  assign pslverr = psel & penable & (~mapped |
                   (pwrite & (paddr[9:0] == e1tsm_pkg::TX_CAPTURE_ADDR ||
                              paddr[9:0] == e1tsm_pkg::RX_CAPTURE_ADDR)));

  // Read data is taken in the setup cycle, so it already stands when the access phase samples it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // Control-four bits 6..5 and control-five bit 7 are forced to zero so they always read back as zero; control-five keeps bits 6..5.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      common_control_four_q <= e1tsm_pkg::CTRL_RESET;
    end else if (wr_en && mapped && paddr[9:0] == e1tsm_pkg::CTRL_FOUR_ADDR) begin
      common_control_four_q <= pwdata[7:0] & e1tsm_pkg::CTRL_FOUR_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      common_control_five_q <= e1tsm_pkg::CTRL_RESET;
    end else if (wr_en && mapped && paddr[9:0] == e1tsm_pkg::CTRL_FIVE_ADDR) begin
      common_control_five_q <= pwdata[7:0] & e1tsm_pkg::CTRL_FIVE_MASK;
    end
  end

  assign remote_loopback_enable = common_control_four_q[e1tsm_pkg::LOOPBACK_BIT];

  // The two capture paths are identical; separate instances keep them independent.
  e1tsm_slot_tap u_tx_tap (
    .pclk       (pclk),
    .presetn    (presetn),
    .line_bit   (tx_data),
    .frame_sync (tx_frame_sync),
    .bit_valid  (tx_bit_valid),
    .slot_sel   (common_control_four_q[e1tsm_pkg::SEL_MSB:e1tsm_pkg::SEL_LSB]),
    .octet      (tx_slot_octet_capture_q)
  );

  e1tsm_slot_tap u_rx_tap (
    .pclk       (pclk),
    .presetn    (presetn),
    .line_bit   (rx_data),
    .frame_sync (rx_frame_sync),
    .bit_valid  (rx_bit_valid),
    .slot_sel   (common_control_five_q[e1tsm_pkg::SEL_MSB:e1tsm_pkg::SEL_LSB]),
    .octet      (rx_slot_octet_capture_q)
  );

endmodule

// Framer stream inputs come from another clock, so each passes three stages.
module e1tsm_slot_tap (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       line_bit,
  input  wire logic       frame_sync,
  input  wire logic       bit_valid,
  input  wire logic [4:0] slot_sel,
  output logic [7:0]      octet
);

  logic [2:0] bit_sync_q;
  logic [2:0] fs_sync_q;
  logic [2:0] bv_sync_q;
  logic       bv_level_q;
  logic       fs_level_q;
  logic [7:0] bit_pos_q;
  logic [7:0] shift_q;
  logic       bv_rise;
  logic       bv_now;
  logic       fs_now;
  logic [7:0] pos_here;
  logic [7:0] sel_end;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_sync_q <= 3'h0;
      fs_sync_q  <= 3'h0;
      bv_sync_q  <= 3'h0;
    end else begin
      bit_sync_q <= {bit_sync_q[1:0], line_bit};
      fs_sync_q  <= {fs_sync_q[1:0], frame_sync};
      bv_sync_q  <= {bv_sync_q[1:0], bit_valid};
    end
  end

  // A change is believed only once the second and third stages agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bv_level_q <= 1'b0;
      fs_level_q <= 1'b0;
    end else begin
      if (bv_sync_q[1] == bv_sync_q[2]) bv_level_q <= bv_sync_q[2];
      if (fs_sync_q[1] == fs_sync_q[2]) fs_level_q <= fs_sync_q[2];
    end
  end

  assign bv_now   = (bv_sync_q[1] == bv_sync_q[2]) ? bv_sync_q[2] : bv_level_q;
  assign fs_now   = (fs_sync_q[1] == fs_sync_q[2]) ? fs_sync_q[2] : fs_level_q;
  assign bv_rise  = bv_now & ~bv_level_q;
  // Frame sync stands high through the whole first bit of slot 0, so it is taken as a level
  // when that bit's valid edge arrives; the two rising edges lie half a bit apart and never meet.
  // This lets the count lock to any frame, not only to the one that follows reset.
  // A stream that starts mid-frame gives wrong captures until its first frame sync.
  assign pos_here = (fs_now && bv_rise) ? 8'h00 : bit_pos_q;
  assign sel_end  = {slot_sel, 3'h7};

  // The position wraps at 256, one frame, so it stays in step between frame syncs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_pos_q <= 8'h00;
    end else if (bv_rise) begin
      bit_pos_q <= pos_here + 8'h01;
    end
  end

  // First bit on the line ends up in bit 7.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= 8'h00;
    end else if (bv_rise) begin
      shift_q <= {shift_q[6:0], bit_sync_q[2]};
    end
  end

  // A new select takes effect at the next end of the chosen slot; until then the old octet stands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      octet <= e1tsm_pkg::CAPTURE_RESET;
    end else if (bv_rise && pos_here == sel_end) begin
      octet <= {shift_q[6:0], bit_sync_q[2]};
    end
  end

endmodule

// >>> tb/e1tsm_stream_gen.sv
`timescale 1ns/1ps
// Framer stream: ten pclk per bit, so the edge filter in the monitor always sees a settled level.
// A non-zero start makes the monitor find the frame from frame sync rather than from reset.
module e1tsm_stream_gen #(parameter logic [7:0] BASE = 8'h00, parameter logic [7:0] START = 8'h00) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      line_bit,
  output logic      frame_sync,
  output logic      bit_valid
);
  logic [3:0] ph_q;
  logic [7:0] bit_q;
  logic [7:0] oct;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 4'h0;
      bit_q <= START;
    end else begin
      ph_q <= (ph_q == 4'h9) ? 4'h0 : ph_q + 4'h1;
      if (ph_q == 4'h9) bit_q <= bit_q + 8'h01;
    end
  end
  assign oct = BASE ^ {3'h0, bit_q[7:3]};
  assign bit_valid = ph_q >= 4'h5;
  assign line_bit = oct[3'h7 - bit_q[2:0]];
  assign frame_sync = bit_q == 8'h00;
endmodule

// >>> tb/e1tsm_monitor_chk.sv
`timescale 1ns/1ps
module e1tsm_monitor_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        remote_loopback_enable
);
  localparam logic [11:0] A4 = {2'b00, e1tsm_pkg::CTRL_FOUR_ADDR};
  localparam logic [11:0] A5 = {2'b00, e1tsm_pkg::CTRL_FIVE_ADDR};
  localparam logic [11:0] AT = {2'b00, e1tsm_pkg::TX_CAPTURE_ADDR};
  localparam logic [11:0] AR = {2'b00, e1tsm_pkg::RX_CAPTURE_ADDR};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       acc;
  logic       hit;
  logic [7:0] s4_q;
  logic [7:0] s5_q;
  assign acc = psel && penable;
  assign hit = paddr == A4 || paddr == A5 || paddr == AT || paddr == AR;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s4_q <= 8'h00;
      s5_q <= 8'h00;
    end else begin
      if (acc && pwrite && paddr == A4) s4_q <= pwdata[7:0] & e1tsm_pkg::CTRL_FOUR_MASK;
      if (acc && pwrite && paddr == A5) s5_q <= pwdata[7:0] & e1tsm_pkg::CTRL_FIVE_MASK;
    end
  end
  a_ready_always: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (acc && !hit |-> pslverr) else $error("no error");
  a_err_capwrite: assert property (acc && pwrite && (paddr == AT || paddr == AR) |-> pslverr)
    else $error("no error");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h000000) else $error("upper");
  a_loop_follow: assert property (acc && pwrite && paddr == A4 |=> remote_loopback_enable == $past(pwdata[7]))
    else $error("loopback");
  a_sel4_readback: assert property (acc && !pwrite && paddr == A4 |-> prdata[7:0] == s4_q) else $error("ctl4");
  a_sel5_readback: assert property (acc && !pwrite && paddr == A5 |-> prdata[7:0] == s5_q) else $error("ctl5");
  a_rdata_hold: assert property (!psel |=> $stable(prdata)) else $error("prdata moved");
  c_wr4: cover property (acc && pwrite && paddr == A4);
  c_rdtx: cover property (acc && !pwrite && paddr == AT);
  c_err: cover property (acc && pslverr);
endmodule
bind e1tsm_monitor e1tsm_monitor_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .prdata, .remote_loopback_enable);

// >>> tb/tb_e1tsm_monitor.sv
`timescale 1ns/1ps
module tb_e1tsm_monitor;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic        pready, pslverr, remote_loopback_enable, tx_data, tx_frame_sync, tx_bit_valid;
  logic        rx_data, rx_frame_sync, rx_bit_valid, e;
  int          n_errors = 0, n_compared = 0;
  logic [4:0]  tsel [3] = '{5'h05, 5'h00, 5'h1F};
  logic [4:0]  rsel [3] = '{5'h0E, 5'h1F, 5'h00};
  logic [7:0]  texp [3] = '{8'hA0, 8'hA5, 8'hBA};
  logic [7:0]  rexp [3] = '{8'h32, 8'h23, 8'h3C};
  always #50 pclk = ~pclk;
  e1tsm_monitor dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .tx_data, .tx_frame_sync, .tx_bit_valid, .rx_data, .rx_frame_sync, .rx_bit_valid, .remote_loopback_enable);
  e1tsm_stream_gen #(.BASE(8'hA5)) tx_u (.pclk, .presetn, .line_bit(tx_data), .frame_sync(tx_frame_sync),
    .bit_valid(tx_bit_valid));
  // The receive stream starts mid-frame, so its captures depend on frame sync.
  e1tsm_stream_gen #(.BASE(8'h3C), .START(8'h90)) rx_u (.pclk, .presetn, .line_bit(rx_data), .frame_sync(rx_frame_sync),
    .bit_valid(rx_bit_valid));
  task automatic results();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic fail(input string m);
    n_errors++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      fail("bus timeout");
      results();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [7:0] x, input logic xe);
    apb(w, a, d);
    n_compared++;
    if (e !== xe || (!w && r !== {24'h000000, x})) fail("bus result");
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk(0, e1tsm_pkg::CTRL_FOUR_ADDR, 0, 8'h00, 0);
    chk(0, e1tsm_pkg::CTRL_FIVE_ADDR, 0, 8'h00, 0);
    for (int i = 0; i < 3; i++) begin
      chk(1, e1tsm_pkg::CTRL_FOUR_ADDR, {3'b100, tsel[i]}, 0, 0);
      chk(1, e1tsm_pkg::CTRL_FIVE_ADDR, {3'b000, rsel[i]}, 0, 0);
      repeat (5200) @(posedge pclk);
      chk(0, e1tsm_pkg::TX_CAPTURE_ADDR, 0, texp[i], 0);
      chk(0, e1tsm_pkg::RX_CAPTURE_ADDR, 0, rexp[i], 0);
      n_compared++;
      if (remote_loopback_enable !== 1'b1) fail("loopback");
    end
    chk(1, e1tsm_pkg::TX_CAPTURE_ADDR, 8'h55, 0, 1);
    chk(0, e1tsm_pkg::TX_CAPTURE_ADDR, 0, 8'hBA, 0);
    chk(0, 12'h000, 0, 8'h00, 1);
    chk(1, e1tsm_pkg::RX_CAPTURE_ADDR, 8'hAA, 8'h00, 1);
    chk(0, e1tsm_pkg::RX_CAPTURE_ADDR, 0, 8'h3C, 0);
    chk(1, e1tsm_pkg::CTRL_FOUR_ADDR, 8'hFF, 0, 0);
    chk(0, e1tsm_pkg::CTRL_FOUR_ADDR, 0, 8'h9F, 0);
    chk(1, e1tsm_pkg::CTRL_FIVE_ADDR, 8'hFF, 0, 0);
    chk(0, e1tsm_pkg::CTRL_FIVE_ADDR, 0, 8'h7F, 0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    n_compared++;
    if (remote_loopback_enable !== 1'b0) fail("loopback after reset");
    chk(0, e1tsm_pkg::CTRL_FOUR_ADDR, 0, 8'h00, 0);
    chk(0, e1tsm_pkg::CTRL_FIVE_ADDR, 0, 8'h00, 0);
    chk(0, e1tsm_pkg::TX_CAPTURE_ADDR, 0, 8'h00, 0);
    chk(0, e1tsm_pkg::RX_CAPTURE_ADDR, 0, 8'h00, 0);
    results();
  end
endmodule
